// ---- hw/bdsw_pkg.sv ----
/*
 Constants for the deep sleep external wake block: register map,
 field layout, reset values and the state encoding.
 Assumes a 32-bit AXI4-Lite register bus and a single core clock.
*/
package bdsw_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_DURATION = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0c;
    localparam logic [7:0] OFS_LAST_SLEEP = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam int ADDR_W = 8;
    // ----------------------------------------
    // Fields
    // ----------------------------------------
    localparam int BIT_WAKE_REQ = 0;
    localparam int BIT_WAKE_DIS = 1;
    localparam int BIT_SLEEP_ON = 2;
    localparam int LEAD_W = 8;
    localparam int DUR_W = 24;
    localparam int POS_SET_LEAD = 0;
    localparam int POS_DEASSERT_LEAD = 8;
    localparam int POS_PULSE_LEN = 16;
    localparam int EV_W = 3;
    localparam int EV_WAKE = 0;
    localparam int EV_EXIT = 1;
    localparam int EV_REFUSED = 2;
    localparam int SYNC_W = 3;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [LEAD_W-1:0] RST_SET_LEAD = 8'h10;
    localparam logic [LEAD_W-1:0] RST_DEASSERT_LEAD = 8'h01;
    localparam logic [LEAD_W-1:0] RST_PULSE_LEN = 8'h02;
    localparam logic [DUR_W-1:0] RST_DURATION = 24'h00_0100;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ----------------------------------------
    // Sleep states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_EXT_WAKE = 4'b0100,
        ST_WAIT_POWER = 4'b1000
    } bdsw_state_e;
endpackage

// ---- hw/bdsw_sync.sv ----
/*
 Three-flop synchroniser for pin levels.
 Assumes asynchronous inputs; the output moves once stages two and three agree.
*/
`timescale 1ns/1ns
module bdsw_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_level;

    always_comb begin
        next_level = level;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_level[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule

// ---- hw/bdsw_top.sv ----
/*
 Deep sleep wake sequencer with an AXI4-Lite register slave.
 Assumes the low-power clock, core clock-enable and radio power-good arrive as pins.
*/
// Our own choices: the address map and the AXI4-Lite slave port.
// What this block does
// - Wake interrupt rises at once when the wake request becomes one.
// - External wake interrupt high time is the pulse length field less the deassert lead, at least one tick.
// - Sleep entry refused while the wake request stays high.
// - Wake disable bit makes the wake request ignored.
// - Wake interrupt comes before the sleep exit interrupt, but never rises if set and drop points share a tick before period end.
// - Deassert lead: low-power cycles before period end that wake interrupt drops.
// - After the period, sleep holds until the core is powered; duration grows.
// - Timer expired, clocks on, radio powered: exit and pulse sleep exit.
`timescale 1ns/1ns
module bdsw_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pins
    input wire logic lowpower_clock,
    input wire logic core_clk_enabled,
    input wire logic radio_powered,
    output logic lowpower_wake_irq,
    output logic sleep_exit_irq,
    output logic in_deep_sleep,
    output logic irq,
    // AXI4-Lite write
    input wire logic [bdsw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [bdsw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [bdsw_pkg::SYNC_W-1:0] pin_lvl;
    logic lp_prev, lp_tick, clk_ok, pwr_ok;

    bdsw_sync #(.W(bdsw_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({radio_powered, core_clk_enabled, lowpower_clock}),
        .level(pin_lvl)
    );
    assign lp_tick = pin_lvl[0] & ~lp_prev;
    assign clk_ok = pin_lvl[1];
    assign pwr_ok = pin_lvl[2];

    // ----------------------------------------
    // Registers and bus
    // ----------------------------------------
    logic ext_wake_request, ext_wake_disable, sleep_go;
    logic [bdsw_pkg::LEAD_W-1:0] set_lead, wake_irq_deassert_lead, ext_wake_pulse_len;
    logic [bdsw_pkg::DUR_W-1:0] sleep_duration, last_sleep;
    logic [bdsw_pkg::EV_W-1:0] irq_status, irq_mask, events;
    logic aw_held, w_held;
    logic [bdsw_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_ext_wake_request, next_ext_wake_disable, next_sleep_go;
    logic [bdsw_pkg::LEAD_W-1:0] next_set_lead, next_deassert_lead, next_pulse_len;
    logic [bdsw_pkg::DUR_W-1:0] next_sleep_duration;
    logic [bdsw_pkg::EV_W-1:0] next_irq_status, next_irq_mask;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_irq;
    logic [bdsw_pkg::ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata, rd_val;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic do_write, do_read, rd_hit;

    // Core state, declared here for the read mux
    bdsw_pkg::bdsw_state_e state, next_state;
    logic [bdsw_pkg::DUR_W-1:0] cnt, next_cnt, next_last_sleep;
    logic [bdsw_pkg::LEAD_W-1:0] pulse, next_pulse;
    logic wake_seen, next_wake_seen, next_wake_irq, next_exit_irq, ext_req_eff;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            bdsw_pkg::OFS_CONTROL: rd_val = {29'h0, 1'b0, ext_wake_disable, ext_wake_request};
            bdsw_pkg::OFS_TIMING: rd_val = {8'h00, ext_wake_pulse_len, wake_irq_deassert_lead, set_lead};
            bdsw_pkg::OFS_DURATION: rd_val = {8'h00, sleep_duration};
            bdsw_pkg::OFS_STATE: rd_val = {26'h0, wake_seen, lowpower_wake_irq, state};
            bdsw_pkg::OFS_LAST_SLEEP: rd_val = {8'h00, last_sleep};
            bdsw_pkg::OFS_IRQ_STATUS: rd_val = {29'h0, irq_status};
            bdsw_pkg::OFS_IRQ_MASK: rd_val = {29'h0, irq_mask};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_ext_wake_request = ext_wake_request;
        next_ext_wake_disable = ext_wake_disable;
        next_sleep_go = 1'b0;
        next_set_lead = set_lead;
        next_deassert_lead = wake_irq_deassert_lead;
        next_pulse_len = ext_wake_pulse_len;
        next_sleep_duration = sleep_duration;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        do_read = s_axi_arvalid && s_axi_arready;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = bdsw_pkg::RESP_OKAY;
            case (aw_addr)
                bdsw_pkg::OFS_CONTROL: begin
                    if (w_strb[0]) begin
                        next_ext_wake_request = w_data[bdsw_pkg::BIT_WAKE_REQ];
                        next_ext_wake_disable = w_data[bdsw_pkg::BIT_WAKE_DIS];
                        next_sleep_go = w_data[bdsw_pkg::BIT_SLEEP_ON];
                    end
                end
                bdsw_pkg::OFS_TIMING: begin
                    if (w_strb[0]) next_set_lead = w_data[bdsw_pkg::POS_SET_LEAD +: bdsw_pkg::LEAD_W];
                    if (w_strb[1]) next_deassert_lead = w_data[bdsw_pkg::POS_DEASSERT_LEAD +: bdsw_pkg::LEAD_W];
                    if (w_strb[2]) next_pulse_len = w_data[bdsw_pkg::POS_PULSE_LEN +: bdsw_pkg::LEAD_W];
                end
                bdsw_pkg::OFS_DURATION: begin
                    if (w_strb[0]) next_sleep_duration[7:0] = w_data[7:0];
                    if (w_strb[1]) next_sleep_duration[15:8] = w_data[15:8];
                    if (w_strb[2]) next_sleep_duration[23:16] = w_data[23:16];
                end
                bdsw_pkg::OFS_IRQ_MASK: begin
                    if (w_strb[0]) next_irq_mask = w_data[bdsw_pkg::EV_W-1:0];
                end
                bdsw_pkg::OFS_STATE, bdsw_pkg::OFS_LAST_SLEEP, bdsw_pkg::OFS_IRQ_STATUS: ;
                default: next_bresp = bdsw_pkg::RESP_SLVERR;
            endcase
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rdata = rd_val;
            next_rresp = rd_hit ? bdsw_pkg::RESP_OKAY : bdsw_pkg::RESP_SLVERR;
            if (s_axi_araddr == bdsw_pkg::OFS_IRQ_STATUS) next_irq_status = '0;
        end
        // Set wins over read clear
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bdsw_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bdsw_pkg::RESP_OKAY;
            ext_wake_request <= 1'b0;
            ext_wake_disable <= 1'b0;
            sleep_go <= 1'b0;
            set_lead <= bdsw_pkg::RST_SET_LEAD;
            wake_irq_deassert_lead <= bdsw_pkg::RST_DEASSERT_LEAD;
            ext_wake_pulse_len <= bdsw_pkg::RST_PULSE_LEN;
            sleep_duration <= bdsw_pkg::RST_DURATION;
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= ~next_aw_held & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~next_w_held & ~(s_axi_wvalid & s_axi_wready);
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= ~next_rvalid & ~do_read;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            ext_wake_request <= next_ext_wake_request;
            ext_wake_disable <= next_ext_wake_disable;
            sleep_go <= next_sleep_go;
            set_lead <= next_set_lead;
            wake_irq_deassert_lead <= next_deassert_lead;
            ext_wake_pulse_len <= next_pulse_len;
            sleep_duration <= next_sleep_duration;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // ----------------------------------------
    // Sleep sequencer
    // ----------------------------------------
    logic [bdsw_pkg::DUR_W-1:0] cnt_inc, set_at, drop_at;
    logic [bdsw_pkg::LEAD_W-1:0] ext_high;

    always_comb begin
        ext_req_eff = ext_wake_request & ~ext_wake_disable;
        cnt_inc = cnt + 1'b1;
        set_at = sleep_duration - {16'h0000, set_lead};
        drop_at = sleep_duration - {16'h0000, wake_irq_deassert_lead};
        ext_high = (ext_wake_pulse_len > wake_irq_deassert_lead) ?
            ext_wake_pulse_len - wake_irq_deassert_lead : 8'h01;
        next_state = state;
        next_cnt = cnt;
        next_pulse = pulse;
        next_wake_seen = wake_seen;
        next_wake_irq = lowpower_wake_irq;
        next_exit_irq = 1'b0;
        next_last_sleep = last_sleep;
        events = '0;
        case (state)
            bdsw_pkg::ST_ACTIVE: begin
                if (sleep_go) begin
                    if (ext_req_eff) begin
                        events[bdsw_pkg::EV_REFUSED] = 1'b1;
                    end else begin
                        next_state = bdsw_pkg::ST_SLEEP;
                        next_cnt = '0;
                        next_wake_seen = 1'b0;
                    end
                end
            end
            bdsw_pkg::ST_SLEEP: begin
                if (ext_req_eff) begin
                    next_wake_irq = 1'b1;
                    next_wake_seen = 1'b1;
                    next_pulse = ext_high;
                    next_state = bdsw_pkg::ST_EXT_WAKE;
                    events[bdsw_pkg::EV_WAKE] = ~lowpower_wake_irq;
                end else if (lp_tick) begin
                    next_cnt = cnt_inc;
                    if (cnt_inc == set_at) begin
                        next_wake_irq = 1'b1;
                        next_wake_seen = 1'b1;
                        events[bdsw_pkg::EV_WAKE] = 1'b1;
                    end
                    if (cnt_inc == drop_at) next_wake_irq = 1'b0;
                    if (cnt_inc >= sleep_duration) begin
                        // Wake interrupt still owed when the set point was never met
                        if (!wake_seen && !next_wake_irq) begin
                            next_wake_irq = 1'b1;
                            events[bdsw_pkg::EV_WAKE] = 1'b1;
                        end
                        next_wake_seen = 1'b1;
                        next_state = bdsw_pkg::ST_WAIT_POWER;
                    end
                end
            end
            bdsw_pkg::ST_EXT_WAKE: begin
                if (lp_tick) begin
                    next_cnt = cnt_inc;
                    next_pulse = pulse - 1'b1;
                    if (pulse <= 8'h01) begin
                        next_wake_irq = 1'b0;
                        next_state = bdsw_pkg::ST_WAIT_POWER;
                    end
                end
            end
            bdsw_pkg::ST_WAIT_POWER: begin
                next_wake_irq = 1'b0;
                if (lp_tick) next_cnt = cnt_inc;
                if (clk_ok && pwr_ok && wake_seen && !lowpower_wake_irq) begin
                    next_exit_irq = 1'b1;
                    next_last_sleep = cnt;
                    next_state = bdsw_pkg::ST_ACTIVE;
                    events[bdsw_pkg::EV_EXIT] = 1'b1;
                end
            end
            default: next_state = bdsw_pkg::ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= bdsw_pkg::ST_ACTIVE;
            cnt <= '0;
            pulse <= '0;
            wake_seen <= 1'b0;
            lowpower_wake_irq <= 1'b0;
            sleep_exit_irq <= 1'b0;
            in_deep_sleep <= 1'b0;
            last_sleep <= '0;
            lp_prev <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pulse <= next_pulse;
            wake_seen <= next_wake_seen;
            lowpower_wake_irq <= next_wake_irq;
            sleep_exit_irq <= next_exit_irq;
            in_deep_sleep <= (next_state != bdsw_pkg::ST_ACTIVE);
            last_sleep <= next_last_sleep;
            lp_prev <= pin_lvl[0];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence ext_start;
        state == bdsw_pkg::ST_SLEEP && ext_req_eff;
    endsequence
    sequence exit_ready;
        state == bdsw_pkg::ST_WAIT_POWER && clk_ok && pwr_ok && wake_seen && !lowpower_wake_irq;
    endsequence

    a_ext_wake_rise: assert property (ext_start |=> lowpower_wake_irq && state == bdsw_pkg::ST_EXT_WAKE)
        else $error("wake irq not raised on request");
    a_ext_pulse_end: assert property (state == bdsw_pkg::ST_EXT_WAKE && lp_tick && pulse <= 8'h01
        |=> !lowpower_wake_irq)
        else $error("external wake pulse too long");
    a_sleep_refused: assert property (state == bdsw_pkg::ST_ACTIVE && sleep_go && ext_req_eff
        |=> state == bdsw_pkg::ST_ACTIVE && irq_status[bdsw_pkg::EV_REFUSED])
        else $error("sleep entered while wake request high");
    a_disable_ignored: assert property (state == bdsw_pkg::ST_SLEEP && ext_wake_disable && !lp_tick
        |=> state == bdsw_pkg::ST_SLEEP && $stable(lowpower_wake_irq))
        else $error("disabled wake request acted on");
    a_exit_order: assert property (sleep_exit_irq |-> $past(wake_seen) && !lowpower_wake_irq)
        else $error("sleep exit before wake irq");
    a_lead_drop: assert property (state == bdsw_pkg::ST_SLEEP && !ext_req_eff && lp_tick
        && cnt_inc == drop_at |=> !lowpower_wake_irq)
        else $error("wake irq did not drop at lead");
    a_hold_unpowered: assert property (state == bdsw_pkg::ST_WAIT_POWER && !(clk_ok && pwr_ok)
        |=> !sleep_exit_irq && state == bdsw_pkg::ST_WAIT_POWER)
        else $error("sleep left without power");
    a_exit_pulse: assert property (exit_ready |=> sleep_exit_irq ##1 !sleep_exit_irq && !in_deep_sleep)
        else $error("sleep exit pulse wrong");
endmodule

// ---- bench/bdsw_power_model.sv ----
/*
 Far-side model: low-power clock source and system power management.
 Assumes the bench raises power_req when software would power the core.
*/
`timescale 1ns/1ns
module bdsw_power_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control from the bench
    input wire logic power_req,
    input wire logic slow,
    // Pins
    output logic lowpower_clock,
    output logic core_clk_enabled,
    output logic radio_powered
);
    logic [3:0] lp_cnt;
    logic [7:0] pw_cnt;
    always_ff @(posedge clk) begin
        lp_cnt <= nrst ? lp_cnt + 4'h1 : 4'h0;
        pw_cnt <= (!nrst || !power_req) ? 8'h00 : pw_cnt + {7'h00, pw_cnt != 8'hff};
    end
    // One low-power tick every 16 core cycles
    assign lowpower_clock = lp_cnt[3];
    // Clocks first, radio power later; slow mode stretches both
    assign core_clk_enabled = pw_cnt >= (slow ? 8'h28 : 8'h02);
    assign radio_powered = pw_cnt >= (slow ? 8'h50 : 8'h04);
endmodule

// ---- bench/ble_deep_sleep_external_wake_bench.sv ----
/*
 Self-checking bench for the deep sleep wake sequencer.
 Assumes bdsw_pkg, bdsw_top and bdsw_power_model are compiled first.
*/
`timescale 1ns/1ns
module ble_deep_sleep_external_wake_bench;
    logic clk, nrst, power_req, slow, wake_flag;
    logic lowpower_clock, core_clk_enabled, radio_powered;
    logic lowpower_wake_irq, sleep_exit_irq, in_deep_sleep, irq;
    logic [bdsw_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total, checks_done, bad_order;

    bdsw_power_model u_pm (.clk(clk), .nrst(nrst), .power_req(power_req), .slow(slow),
        .lowpower_clock(lowpower_clock), .core_clk_enabled(core_clk_enabled), .radio_powered(radio_powered));
    bdsw_top u_dut (.clk(clk), .nrst(nrst), .lowpower_clock(lowpower_clock),
        .core_clk_enabled(core_clk_enabled), .radio_powered(radio_powered),
        .lowpower_wake_irq(lowpower_wake_irq), .sleep_exit_irq(sleep_exit_irq),
        .in_deep_sleep(in_deep_sleep), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Exit pulse without a wake interrupt since the last exit
    always @(posedge clk) begin
        if (!nrst) begin
            wake_flag <= 1'b0;
            bad_order <= 0;
        end else begin
            if (lowpower_wake_irq) wake_flag <= 1'b1;
            if (sleep_exit_irq) begin
                if (!wake_flag) bad_order <= bad_order + 1;
                wake_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("err_total=%0d checks_done=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100) err_total++;
    endtask

    task automatic rdreg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) err_total++;
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return lowpower_wake_irq;
            1: return sleep_exit_irq;
            default: return in_deep_sleep;
        endcase
    endfunction

    task automatic wait_lvl(input int s, input logic lvl, input int lim, output int n);
        n = 0;
        while (sig(s) !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdreg(bdsw_pkg::OFS_TIMING);
        chk("timing_reset", 32'h0002_0110, rd);
        rdreg(bdsw_pkg::OFS_DURATION);
        chk("duration_reset", 32'h0000_0100, rd);
        rdreg(bdsw_pkg::OFS_IRQ_MASK);
        chk("mask_reset", 32'h0000_0000, rd);
        rdreg(bdsw_pkg::OFS_STATE);
        chk("state_active", 32'h0000_0001, rd);
        rdreg(8'h1c);
        chk("unmapped_rresp", {30'h0000_0000, bdsw_pkg::RESP_SLVERR}, {30'h0000_0000, rsp});
        wr(8'h1c, 32'h0000_0001);
        chk("unmapped_bresp", {30'h0000_0000, bdsw_pkg::RESP_SLVERR}, {30'h0000_0000, rsp});
    endtask

    task automatic t_refuse();
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0001);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0005);
        repeat (4) @(posedge clk);
        chk("sleep_refused", 32'h0000_0000, in_deep_sleep);
        chk("irq_masked", 32'h0000_0000, irq);
        wr(bdsw_pkg::OFS_IRQ_MASK, 32'h0000_0007);
        repeat (3) @(posedge clk);
        chk("irq_raised", 32'h0000_0001, irq);
        rdreg(bdsw_pkg::OFS_IRQ_STATUS);
        chk("status_refused", 32'h0000_0004, rd);
        repeat (3) @(posedge clk);
        chk("irq_cleared", 32'h0000_0000, irq);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0000);
    endtask

    task automatic t_ext(input logic [7:0] pl);
        int n, k;
        k = int'(pl) - 1;
        power_req <= 1'b0;
        wr(bdsw_pkg::OFS_TIMING, {8'h00, pl, 16'h0110});
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0004);
        wait_lvl(2, 1'b1, 10, n);
        chk("asleep", 32'h0000_0001, in_deep_sleep);
        repeat (40) @(posedge clk);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0001);
        wait_lvl(0, 1'b1, 6, n);
        chk("wake_at_once", 32'h0000_0001, lowpower_wake_irq);
        wait_lvl(0, 1'b0, 400, n);
        chk("ext_high_time", 32'h0000_0001, n > (k - 1) * 16 && n <= k * 16 + 6);
        repeat (40) @(posedge clk);
        chk("held_unpowered", 32'h0000_0001, in_deep_sleep);
        power_req <= 1'b1;
        wait_lvl(1, 1'b1, 40, n);
        chk("exit_pulse", 32'h0000_0001, sleep_exit_irq);
        repeat (2) @(posedge clk);
        chk("awake", 32'h0000_0000, in_deep_sleep);
        chk("irq_exit", 32'h0000_0001, irq);
        chk("exit_order", 32'h0000_0000, bad_order);
        rdreg(bdsw_pkg::OFS_IRQ_STATUS);
        chk("status_wake_exit", 32'h0000_0003, rd);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0000);
    endtask

    task automatic t_timer();
        int n;
        power_req <= 1'b0;
        slow <= 1'b1;
        wr(bdsw_pkg::OFS_TIMING, 32'h0002_0104);
        wr(bdsw_pkg::OFS_DURATION, 32'h0000_0010);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0006);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0003);
        repeat (32) @(posedge clk);
        chk("disabled_request", 32'h0000_0000, lowpower_wake_irq);
        chk("still_asleep", 32'h0000_0001, in_deep_sleep);
        wait_lvl(0, 1'b1, 300, n);
        chk("timer_wake", 32'h0000_0001, lowpower_wake_irq);
        wait_lvl(0, 1'b0, 100, n);
        chk("lead_high_time", 32'h0000_0001, n > 32 && n <= 54);
        power_req <= 1'b1;
        wait_lvl(1, 1'b1, 200, n);
        chk("power_wait", 32'h0000_0001, n >= 70 && n < 200);
        chk("exit_order", 32'h0000_0000, bad_order);
        rdreg(bdsw_pkg::OFS_LAST_SLEEP);
        chk("sleep_grown", 32'h0000_0001, rd[23:0] > 24'h00_0010);
        wr(bdsw_pkg::OFS_CONTROL, 32'h0000_0000);
        slow <= 1'b0;
    endtask

    initial begin
        nrst = 1'b0;
        power_req = 1'b0;
        slow = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        err_total = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_refuse();
        t_ext(8'h02);
        t_ext(8'h04);
        t_timer();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule
